// [common/cam_seq_pkg.sv]
// constants and types shared by the camera sequencing controller
package cam_seq_pkg;
  // ****************************************
  // clock and pixel timing
  // ****************************************
  localparam int CLK_MHZ          = 50;
  localparam int PIXEL_PERIOD_US  = 52;
  localparam int SUPPRESS_DLY_US  = 4;
  localparam int SAMPLE_DLY_US    = 20;
  localparam int CLAMP_LEN_US     = 4;
  localparam int SAMPLE_LEN_US    = 8;
  localparam int PIXEL_CYC        = PIXEL_PERIOD_US * CLK_MHZ;
  localparam int SUPPRESS_DLY_CYC = SUPPRESS_DLY_US * CLK_MHZ;
  localparam int SAMPLE_DLY_CYC   = SAMPLE_DLY_US * CLK_MHZ;
  localparam int CLAMP_LEN_CYC    = CLAMP_LEN_US * CLK_MHZ;
  localparam int SAMPLE_LEN_CYC   = SAMPLE_LEN_US * CLK_MHZ;
  localparam int PIX_CNT_W        = 12;

  // ****************************************
  // sequencing figures
  // ****************************************
  localparam int        ERASE_CNT_W      = 8;
  localparam int        LINE_CNT_W       = 9;
  localparam logic [8:0] LINES_AFTER_FIRST = 9'h0ff;
  localparam logic [7:0] ERASE_N_DEFAULT  = 8'h04;

  typedef enum logic [1:0] {
    CMD_IMAGE = 2'h0,
    CMD_SHIFT = 2'h1,
    CMD_READ  = 2'h2
  } cmd_t;

  // gray coded along erase -> armed -> exposing -> transmit path
  typedef enum logic [2:0] {
    ST_ERASE_IT = 3'h0,
    ST_ERASE_LR = 3'h1,
    ST_ARMED    = 3'h3,
    ST_TX_IT    = 3'h2,
    ST_TX_LR0   = 3'h6,
    ST_TX_LT    = 3'h7,
    ST_TX_LR    = 3'h5
  } seq_state_t;
endpackage

// [logic/cdsh_switch_timer.sv]
// sample-and-hold switch timing over one pixel period
`timescale 1ns/10ps
module cdsh_switch_timer
  import cam_seq_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // control
  input  wire logic i_run,
  // switch controls, active low
  output logic      o_suppress_n,
  output logic      o_clamp_n,
  output logic      o_sample_n
);
  // ****************************************
  // pixel phase counter
  // ****************************************
  logic [PIX_CNT_W-1:0] phase_ff;
  localparam logic [PIX_CNT_W-1:0] LAST_PH  = PIX_CNT_W'(PIXEL_CYC - 1);
  localparam logic [PIX_CNT_W-1:0] SUP_ON   = PIX_CNT_W'(SUPPRESS_DLY_CYC);
  localparam logic [PIX_CNT_W-1:0] CLAMP_ON =
    PIX_CNT_W'(PIXEL_CYC - SAMPLE_DLY_CYC - SAMPLE_LEN_CYC - CLAMP_LEN_CYC);
  localparam logic [PIX_CNT_W-1:0] CLAMP_OFF = PIX_CNT_W'(PIXEL_CYC - SAMPLE_DLY_CYC
    - SAMPLE_LEN_CYC);
  localparam logic [PIX_CNT_W-1:0] SAMP_ON  = PIX_CNT_W'(PIXEL_CYC - SAMPLE_LEN_CYC);

  // R15: 52 us period
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_ff <= '0;
    end else if (!i_run || phase_ff == LAST_PH) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= phase_ff + 1'b1;
    end
  end

  // ****************************************
  // switch outputs
  // ****************************************
  // phase 0 is the end of the previous sample period
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_suppress_n <= 1'b1;
      o_clamp_n    <= 1'b1;
      o_sample_n   <= 1'b1;
    end else begin
      // R16: suppress on 4 us after sample
      o_suppress_n <= !(i_run && phase_ff >= SUP_ON && phase_ff < CLAMP_ON);
      o_clamp_n    <= !(i_run && phase_ff >= CLAMP_ON && phase_ff < CLAMP_OFF);
      // R17: sample 20 us after clamp
      o_sample_n   <= !(i_run && phase_ff >= SAMP_ON);
    end
  end
endmodule

// [logic/ccd_camera_readout_sequencer.sv]
// camera sequencing controller: erase loop, picture handshake, readout
`timescale 1ns/10ps
// Notes on behaviour
// R1: erase continuously while idle
// R2: erase cycle is image transfer then read
// R3: erase count N is settable
// R4: computer raises begin-picture to request
// R5: finish current erase before picture
// R6: raise expose line after erase completes
// R7: computer drops begin-picture to transmit
// R8: transmit order IT, LR, LT, LR
// R9: window high when first pixel ready
// R10: telemetry reads pixels, returns control
// R11: repeat transfer-read pair 255 times
// R12: drop expose line after picture done
// R13: busy covers whole generator operation
// R14: enable-ADC only during picture readout
// R15: switch timing on 52 us pixel
// R16: suppress on 4 us after sample
// R17: sample on 20 us after clamp
// R18: each operation starts on own pulse
// R19: wait for busy low before next
module ccd_camera_readout_sequencer
  import cam_seq_pkg::*;
(
  // clock and reset
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RESETN,
  // configuration
  input  wire logic [ERASE_CNT_W-1:0] I_ERASE_N,
  // experiment computer
  input  wire logic                   I_BEGIN_PICTURE,
  output logic                        O_EXPOSE_DONE,
  // clock generator
  input  wire logic                   I_GEN_BUSY,
  input  wire logic                   I_FIRST_PIXEL_READY,
  output logic                        O_IMAGE_TO_STORAGE_CMD,
  output logic                        O_STORAGE_LINE_SHIFT_CMD,
  output logic                        O_LINE_READOUT_CMD,
  // shared status
  output logic                        O_PICTURE_READOUT_ACTIVE,
  output logic                        O_PIXEL_DATA_WINDOW,
  // sample-and-hold switches
  output logic                        O_RESET_SPIKE_SUPPRESS_N,
  output logic                        O_BACKGROUND_CLAMP_N,
  output logic                        O_PIXEL_SAMPLE_N
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic begin_s1_ff, begin_ff, busy_s1_ff, busy_ff, first_s1_ff, first_ff;

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      begin_s1_ff <= 1'b0;
      begin_ff    <= 1'b0;
      busy_s1_ff  <= 1'b0;
      busy_ff     <= 1'b0;
      first_s1_ff <= 1'b0;
      first_ff    <= 1'b0;
    end else begin
      begin_s1_ff <= I_BEGIN_PICTURE;
      begin_ff    <= begin_s1_ff;
      busy_s1_ff  <= I_GEN_BUSY;
      busy_ff     <= busy_s1_ff;
      first_s1_ff <= I_FIRST_PIXEL_READY;
      first_ff    <= first_s1_ff;
    end
  end

  // ****************************************
  // command issue handshake
  // ****************************************
  // a command is pending from its pulse until busy has risen and fallen
  seq_state_t state_ff, nxt_state;
  logic       pending_ff;
  logic       seen_busy_ff;
  logic       issue;
  logic       cmd_done;
  logic [ERASE_CNT_W-1:0] erase_cnt_ff;
  logic [LINE_CNT_W-1:0]  line_cnt_ff;
  logic                   exposing_ff;

  // R13: generator busy ends the operation
  assign cmd_done = pending_ff && seen_busy_ff && !busy_ff;
  // R19: only issue while generator idle
  assign issue    = !pending_ff && !busy_ff && nxt_issue_ok(state_ff, begin_ff, exposing_ff);

  function automatic logic nxt_issue_ok(input seq_state_t st, input logic req,
                                        input logic expo);
    nxt_issue_ok = (st != ST_ARMED) || (expo && !req);
  endfunction

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pending_ff   <= 1'b0;
      seen_busy_ff <= 1'b0;
    end else if (issue && state_ff != ST_ARMED) begin
      pending_ff   <= 1'b1;
      seen_busy_ff <= 1'b0;
    end else if (cmd_done) begin
      pending_ff   <= 1'b0;
      seen_busy_ff <= 1'b0;
    end else if (busy_ff) begin
      seen_busy_ff <= 1'b1;
    end
  end

  // R18: one-cycle pulse per operation
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_IMAGE_TO_STORAGE_CMD   <= 1'b0;
      O_STORAGE_LINE_SHIFT_CMD <= 1'b0;
      O_LINE_READOUT_CMD       <= 1'b0;
    end else begin
      // R2: erase issues image then read
      // R8: transmit order image, read, shift, read
      O_IMAGE_TO_STORAGE_CMD   <= issue && (state_ff == ST_ERASE_IT || state_ff == ST_TX_IT);
      O_STORAGE_LINE_SHIFT_CMD <= issue && state_ff == ST_TX_LT;
      O_LINE_READOUT_CMD       <= issue && (state_ff == ST_ERASE_LR || state_ff == ST_TX_LR0
                                            || state_ff == ST_TX_LR);
    end
  end

  // ****************************************
  // sequence state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_ERASE_IT: if (cmd_done) begin
        nxt_state = ST_ERASE_LR;
      end
      ST_ERASE_LR: if (cmd_done) begin
        // R5: request honoured only at routine end
        if (erase_cnt_ff == '0 && begin_ff) begin
          nxt_state = ST_ARMED;
        end else begin
          // R1: keep erasing while idle
          nxt_state = ST_ERASE_IT;
        end
      end
      // R7: falling request starts transmission
      ST_ARMED: if (exposing_ff && !begin_ff) begin
        nxt_state = ST_TX_IT;
      end
      ST_TX_IT: if (cmd_done) begin
        nxt_state = ST_TX_LR0;
      end
      ST_TX_LR0: if (cmd_done) begin
        nxt_state = ST_TX_LT;
      end
      ST_TX_LT: if (cmd_done) begin
        nxt_state = ST_TX_LR;
      end
      ST_TX_LR: if (cmd_done) begin
        // R11: 255 more line pairs
        nxt_state = (line_cnt_ff == LINES_AFTER_FIRST) ? ST_ERASE_IT : ST_TX_LT;
      end
      default: nxt_state = ST_ERASE_IT;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_ff <= ST_ERASE_IT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // R3: cycles counted down from I_ERASE_N - 1 to zero
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      erase_cnt_ff <= '0;
    end else if (state_ff == ST_ERASE_LR && cmd_done) begin
      erase_cnt_ff <= (erase_cnt_ff == '0) ? ERASE_CNT_W'(I_ERASE_N - 1'b1)
                                           : erase_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      line_cnt_ff <= '0;
    end else if (state_ff == ST_TX_IT) begin
      line_cnt_ff <= '0;
    end else if (state_ff == ST_TX_LR && cmd_done) begin
      line_cnt_ff <= line_cnt_ff + 1'b1;
    end
  end

  // ****************************************
  // computer and telemetry status
  // ****************************************
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      exposing_ff   <= 1'b0;
      O_EXPOSE_DONE <= 1'b0;
    end else if (state_ff == ST_ERASE_LR && nxt_state == ST_ARMED) begin
      // R6: exposure may begin
      exposing_ff   <= 1'b1;
      O_EXPOSE_DONE <= 1'b1;
    end else if (state_ff == ST_TX_LR && nxt_state == ST_ERASE_IT) begin
      // R12: picture complete
      exposing_ff   <= 1'b0;
      O_EXPOSE_DONE <= 1'b0;
    end
  end

  // R14: high only in transmit states
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PICTURE_READOUT_ACTIVE <= 1'b0;
    end else begin
      O_PICTURE_READOUT_ACTIVE <= nxt_state == ST_TX_IT || nxt_state == ST_TX_LR0
                                  || nxt_state == ST_TX_LT || nxt_state == ST_TX_LR;
    end
  end

  // R9: first pixel on bus during line read
  // R10: window held while telemetry reads pixels
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PIXEL_DATA_WINDOW <= 1'b0;
    end else begin
      O_PIXEL_DATA_WINDOW <= state_ff == ST_TX_LR && pending_ff && first_ff;
    end
  end

  // ****************************************
  // sample-and-hold timing
  // ****************************************
  // switches run only during picture readout, to save analog power in erase
  cdsh_switch_timer u_switch_timer (
    .i_clk        (I_MCLK),
    .i_resetn     (I_RESETN),
    .i_run        (O_PICTURE_READOUT_ACTIVE),
    .o_suppress_n (O_RESET_SPIKE_SUPPRESS_N),
    .o_clamp_n    (O_BACKGROUND_CLAMP_N),
    .o_sample_n   (O_PIXEL_SAMPLE_N)
  );
endmodule

// [verif/ccd_camera_readout_sequencer_chk.sv]
// port assertions for the camera sequencer
`timescale 1ns/10ps
module ccd_camera_readout_sequencer_chk
  import cam_seq_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic I_BEGIN_PICTURE,
  input wire logic I_GEN_BUSY,
  input wire logic O_EXPOSE_DONE,
  input wire logic O_IMAGE_TO_STORAGE_CMD,
  input wire logic O_STORAGE_LINE_SHIFT_CMD,
  input wire logic O_LINE_READOUT_CMD,
  input wire logic O_PICTURE_READOUT_ACTIVE,
  input wire logic O_PIXEL_DATA_WINDOW,
  input wire logic O_RESET_SPIKE_SUPPRESS_N,
  input wire logic O_BACKGROUND_CLAMP_N,
  input wire logic O_PIXEL_SAMPLE_N
);
  logic       any_cmd;
  logic [9:0] shift_cnt_ff;
  assign any_cmd = O_IMAGE_TO_STORAGE_CMD | O_STORAGE_LINE_SHIFT_CMD | O_LINE_READOUT_CMD;
  // lines shifted in one readout, cleared while idle
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN)
      shift_cnt_ff <= 10'h000;
    else if (!O_PICTURE_READOUT_ACTIVE)
      shift_cnt_ff <= 10'h000;
    else if (O_STORAGE_LINE_SHIFT_CMD)
      shift_cnt_ff <= shift_cnt_ff + 10'h001;
  end
  // cycles since sample or clamp last opened; zero outside readout, so the
  // first pixel after enable is not judged against a missing earlier sample
  logic [11:0] since_samp_ff;
  logic [11:0] since_clamp_ff;
  logic        samp_q_ff;
  logic        clamp_q_ff;
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      samp_q_ff      <= 1'b1;
      clamp_q_ff     <= 1'b1;
      since_samp_ff  <= 12'h000;
      since_clamp_ff <= 12'h000;
    end else begin
      samp_q_ff  <= O_PIXEL_SAMPLE_N;
      clamp_q_ff <= O_BACKGROUND_CLAMP_N;
      if (!O_PICTURE_READOUT_ACTIVE)
        since_samp_ff <= 12'h000;
      else if (O_PIXEL_SAMPLE_N && !samp_q_ff)
        since_samp_ff <= 12'h001;
      else if (since_samp_ff != 12'h000 && since_samp_ff != 12'hfff)
        since_samp_ff <= since_samp_ff + 12'h001;
      if (!O_PICTURE_READOUT_ACTIVE)
        since_clamp_ff <= 12'h000;
      else if (O_BACKGROUND_CLAMP_N && !clamp_q_ff)
        since_clamp_ff <= 12'h001;
      else if (since_clamp_ff != 12'h000 && since_clamp_ff != 12'hfff)
        since_clamp_ff <= since_clamp_ff + 12'h001;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_read_follows;
    ##[2:300] O_LINE_READOUT_CMD;
  endsequence
  sequence s_pulse_ends;
    ##1 !any_cmd;
  endsequence
  a_pulse_one_cycle: assert property (any_cmd |-> s_pulse_ends)
    else $error("command pulse too long");
  a_one_cmd_only: assert property ($onehot0({O_IMAGE_TO_STORAGE_CMD, O_STORAGE_LINE_SHIFT_CMD,
    O_LINE_READOUT_CMD})) else $error("two commands at once");
  a_image_then_read: assert property (O_IMAGE_TO_STORAGE_CMD |-> s_read_follows)
    else $error("no read after image transfer");
  a_shift_then_read: assert property (O_STORAGE_LINE_SHIFT_CMD |-> s_read_follows)
    else $error("no read after line shift");
  a_idle_while_busy: assert property (I_GEN_BUSY |-> !any_cmd)
    else $error("command while generator busy");
  a_shift_in_readout: assert property (O_STORAGE_LINE_SHIFT_CMD |-> O_PICTURE_READOUT_ACTIVE)
    else $error("line shift outside readout");
  a_quiet_exposure: assert property (O_EXPOSE_DONE && I_BEGIN_PICTURE
    && $past(I_BEGIN_PICTURE, 3) |-> !any_cmd) else $error("command during exposure");
  a_line_total: assert property ($fell(O_PICTURE_READOUT_ACTIVE) |-> shift_cnt_ff == 10'h100)
    else $error("wrong line count");
  a_window_in_read: assert property ($rose(O_PIXEL_DATA_WINDOW)
    |-> O_PICTURE_READOUT_ACTIVE && I_GEN_BUSY) else $error("window outside read");
  a_switch_exclusive: assert property ($onehot0(~{O_RESET_SPIKE_SUPPRESS_N,
    O_BACKGROUND_CLAMP_N, O_PIXEL_SAMPLE_N})) else $error("switches overlap");
  a_suppress_delay: assert property ($fell(O_RESET_SPIKE_SUPPRESS_N)
    && since_samp_ff != 12'h000 |-> since_samp_ff == 12'(SUPPRESS_DLY_CYC))
    else $error("suppress not 4 us after sample");
  a_sample_delay: assert property ($fell(O_PIXEL_SAMPLE_N)
    && since_clamp_ff != 12'h000 |-> since_clamp_ff == 12'(SAMPLE_DLY_CYC))
    else $error("sample not 20 us after clamp");
  a_pixel_period: assert property ($rose(O_PIXEL_SAMPLE_N) && O_PICTURE_READOUT_ACTIVE
    && since_samp_ff != 12'h000 |-> since_samp_ff == 12'(PIXEL_CYC))
    else $error("pixel period wrong");
endmodule

// [verif/cam_gen_model.sv]
// behavioural clock generator answering command pulses
`timescale 1ns/10ps
module cam_gen_model (
  input  wire logic i_clk,
  input  wire logic i_slow,
  input  wire logic i_it,
  input  wire logic i_lt,
  input  wire logic i_lr,
  input  wire logic i_adc_en,
  output logic      o_busy,
  output logic      o_first_px
);
  initial begin
    int   hold;
    logic read;
    o_busy = 1'b0;
    o_first_px = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_it || i_lt || i_lr) begin
        read = i_lr && i_adc_en;
        hold = i_slow ? 24 : 3;
        repeat (i_slow ? 4 : 1) @(posedge i_clk);
        o_busy <= 1'b1;
        if (read) begin
          repeat (2) @(posedge i_clk);
          o_first_px <= 1'b1;
          repeat (hold) @(posedge i_clk);
          o_first_px <= 1'b0;
          repeat (4) @(posedge i_clk);
        end
        repeat (hold) @(posedge i_clk);
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// [verif/ccd_camera_readout_sequencer_tb_top.sv]
// bench for the camera sequencer against the generator model
`timescale 1ns/10ps
module ccd_camera_readout_sequencer_tb_top;
  import cam_seq_pkg::*;
  logic       mclk, resetn, begin_pic, slow, win_q;
  logic [7:0] erase_n;
  wire        expose, busy, first_px, img, shift, rd, adc, win, sup_n, clamp_n, samp_n;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         win_cnt = 0;
  cmd_t       log_q[$];
  ccd_camera_readout_sequencer u_ccd_camera_readout_sequencer (.I_MCLK(mclk),
    .I_RESETN(resetn), .I_ERASE_N(erase_n), .I_BEGIN_PICTURE(begin_pic), .O_EXPOSE_DONE(expose),
    .I_GEN_BUSY(busy), .I_FIRST_PIXEL_READY(first_px), .O_IMAGE_TO_STORAGE_CMD(img),
    .O_STORAGE_LINE_SHIFT_CMD(shift), .O_LINE_READOUT_CMD(rd), .O_PICTURE_READOUT_ACTIVE(adc),
    .O_PIXEL_DATA_WINDOW(win), .O_RESET_SPIKE_SUPPRESS_N(sup_n),
    .O_BACKGROUND_CLAMP_N(clamp_n), .O_PIXEL_SAMPLE_N(samp_n));
  cam_gen_model u_cam_gen_model (.i_clk(mclk), .i_slow(slow), .i_it(img), .i_lt(shift),
    .i_lr(rd), .i_adc_en(adc), .o_busy(busy), .o_first_px(first_px));
  // ****************************************
  // monitor and helpers
  // ****************************************
  always @(posedge mclk) begin
    win_q <= win;
    if (win && !win_q) win_cnt++;
    if (!resetn) log_q.delete();
    else if (img) log_q.push_back(CMD_IMAGE);
    else if (shift) log_q.push_back(CMD_SHIFT);
    else if (rd) log_q.push_back(CMD_READ);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_erase();
    for (int i = 0; i < 4000 && log_q.size() < 8; i++) @(posedge mclk);
    for (int i = 0; i < 8; i++) chk("erase order", (i % 2) ? CMD_READ : CMD_IMAGE, log_q[i]);
    chk("adc in erase", 16'h0000, adc);
    chk("expose idle", 16'h0000, expose);
  endtask
  task automatic t_picture();
    int base;
    int cnt;
    begin_pic <= 1'b1;
    for (int i = 0; i < 40000 && expose !== 1'b1; i++) @(posedge mclk);
    cnt = 0;
    foreach (log_q[i]) cnt += (log_q[i] == CMD_IMAGE);
    chk("last erase step", CMD_READ, log_q[$]);
    chk("whole routines", 16'h0000, 16'((cnt - 1) % erase_n));
    chk("expose raised", 16'h0001, expose);
    base = log_q.size();
    repeat (60) @(posedge mclk);
    chk("quiet exposure", 16'(base), 16'(log_q.size()));
    win_cnt = 0;
    begin_pic <= 1'b0;
    for (int i = 0; i < 60000 && expose !== 1'b0; i++) @(posedge mclk);
    chk("tx image", CMD_IMAGE, log_q[base]);
    chk("tx empty read", CMD_READ, log_q[base + 1]);
    chk("tx first shift", CMD_SHIFT, log_q[base + 2]);
    chk("tx first read", CMD_READ, log_q[base + 3]);
    cnt = 0;
    foreach (log_q[i]) cnt += (i >= base && log_q[i] == CMD_SHIFT);
    chk("lines shifted", 16'h0100, 16'(cnt));
    chk("windows seen", 16'h0100, 16'(win_cnt));
    chk("expose cleared", 16'h0000, expose);
    repeat (4) @(posedge mclk);
    chk("adc after picture", 16'h0000, adc);
  endtask
  task automatic t_reset_mid();
    for (int i = 0; i < 2000 && img !== 1'b1; i++) @(posedge mclk);
    resetn <= 1'b0;
    erase_n <= 8'h02;
    slow <= 1'b1;
    // the model has no reset: hold until its last command is over, else a
    // pulse right after release lands while it is still busy and is lost
    repeat (8) @(posedge mclk);
    chk("reset outputs", 16'h0007, {expose, img, shift, rd, adc, win, sup_n, clamp_n, samp_n});
    resetn <= 1'b1;
  endtask
  // ****************************************
  // clock, sequence and watchdog
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    resetn = 1'b0;
    erase_n = 8'h03;
    begin_pic = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_erase();
    t_picture();
    t_reset_mid();
    t_picture();
    give_verdict();
  end
  // slow picture needs about 25k cycles, so this leaves ample margin
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule
bind ccd_camera_readout_sequencer ccd_camera_readout_sequencer_chk
  u_ccd_camera_readout_sequencer_chk (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
  .I_BEGIN_PICTURE(I_BEGIN_PICTURE), .I_GEN_BUSY(I_GEN_BUSY), .O_EXPOSE_DONE(O_EXPOSE_DONE),
  .O_IMAGE_TO_STORAGE_CMD(O_IMAGE_TO_STORAGE_CMD),
  .O_STORAGE_LINE_SHIFT_CMD(O_STORAGE_LINE_SHIFT_CMD), .O_LINE_READOUT_CMD(O_LINE_READOUT_CMD),
  .O_PICTURE_READOUT_ACTIVE(O_PICTURE_READOUT_ACTIVE), .O_PIXEL_DATA_WINDOW(O_PIXEL_DATA_WINDOW),
  .O_RESET_SPIKE_SUPPRESS_N(O_RESET_SPIKE_SUPPRESS_N),
  .O_BACKGROUND_CLAMP_N(O_BACKGROUND_CLAMP_N), .O_PIXEL_SAMPLE_N(O_PIXEL_SAMPLE_N));
